// ===== rtl/pgs_buck.sv
`timescale 1ns/1ps
module pgs_buck (
	input  wire logic       clock,     // System clock.
	input  wire logic       rst_n,     // Synchronous reset, active low.
	input  wire logic       us_tick,   // One pulse per microsecond.
	input  wire logic       enable,    // Channel enabled.
	input  wire logic       force_pwm, // Keep PWM at light load.
	input  wire logic       ss_short,  // Short soft-start ramp.
	input  wire logic       scale_n,   // Low selects the alternate setpoint.
	input  wire logic       light_load, // Load is light.
	input  wire logic [7:0] nominal,   // Nominal setpoint.
	input  wire logic [7:0] alternate, // Alternate setpoint.
	input  wire logic       sw_tick,   // One pulse per switching cycle.
	input  wire logic       sw_over,   // Current above warning level.
	output logic            ss_done,   // Soft-start ramp finished.
	output logic            save_mode, // Light-load save mode active.
	output logic      [7:0] setpoint,  // Setpoint in use.
	output logic            ilim_warn  // Warning run reached.
);
	import pgs_pkg::*;

	localparam logic [9:0] SS_LONG_T  = 10'(SS_LONG_US / TICK_US);
	localparam logic [9:0] SS_SHORT_T = 10'(SS_SHORT_US / TICK_US);
	localparam logic [4:0] RUN_T      = 5'(ILIM_RUN);

	logic [9:0] ss_cnt_q;
	logic [4:0] run_q;
	wire  [9:0] ss_len_w = ss_short ? SS_SHORT_T : SS_LONG_T;

	// Ramp restarts whenever the channel is re-enabled after a fault.
	always_ff @(posedge clock) begin
		if (!rst_n || !enable) begin
			ss_cnt_q <= '0;
			ss_done  <= 1'b0;
		end else if (!ss_done && us_tick) begin
			ss_cnt_q <= ss_cnt_q + 10'h001;
			ss_done  <= (ss_cnt_q == ss_len_w - 10'h001);
		end
	end

	// Counts consecutive over-level switching cycles after soft-start.
	always_ff @(posedge clock) begin
		if (!rst_n || !enable || !ss_done) begin
			run_q <= '0;
		end else if (sw_tick) begin
			run_q <= !sw_over ? 5'h00 :
				(run_q == RUN_T) ? RUN_T : run_q + 5'h01;
		end
	end

	// Mode, setpoint and warning registers.
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			save_mode <= 1'b0;
			setpoint  <= 8'h00;
			ilim_warn <= 1'b0;
		end else begin
			save_mode <= enable && !force_pwm && light_load;
			setpoint  <= scale_n ? nominal : alternate;
			ilim_warn <= (run_q == RUN_T);
		end
	end

	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);

	chk_scale_setpoint: assert property (
		!scale_n |=> setpoint == $past(alternate))
		else $error("alternate setpoint not taken while scaled");
	chk_force_pwm: assert property (
		force_pwm |=> !save_mode)
		else $error("save mode entered with PWM forced");
	chk_ss_restart: assert property (
		$rose(enable) |=> !ss_done [*2])
		else $error("soft-start skipped on enable");
endmodule : pgs_buck

// ===== rtl/pgs_pkg.sv
package pgs_pkg;
	// Clock and time base.
	localparam int unsigned CLK_HZ      = 50_000_000;
	localparam int unsigned TICK_US     = 1;
	localparam int unsigned TICK_CYC    = CLK_HZ / 1_000_000 * TICK_US;
	localparam int unsigned US_PER_MS   = 1000;
	// Soft-start ramp lengths in microseconds.
	localparam int unsigned SS_LONG_US  = 500;
	localparam int unsigned SS_SHORT_US = 250;
	// Restart wait after a rail fault, in milliseconds.
	localparam int unsigned RESTART_MS  = 10;
	// Reset release delays in milliseconds, one per delay code.
	localparam int unsigned RST_DLY0_MS = 20;
	localparam int unsigned RST_DLY1_MS = 40;
	localparam int unsigned RST_DLY2_MS = 60;
	localparam int unsigned RST_DLY3_MS = 100;
	// Consecutive switching cycles above the warning level.
	localparam int unsigned ILIM_RUN    = 16;
	localparam int unsigned NBUCK       = 3;
	localparam int unsigned NRAIL       = 5;
	// Status register addresses.
	localparam logic [7:0] ST_ADDR_INPUT = 8'h00;
	localparam logic [7:0] ST_ADDR_TEMP  = 8'h30;
	localparam logic [7:0] ST_ADDR_BILIM = 8'h40;
	localparam logic [7:0] ST_ADDR_LILIM = 8'h50;
	localparam logic [7:0] ST_ADDR_UV    = 8'h60;
	localparam logic [7:0] ST_ADDR_OV    = 8'h65;

	// Interrupt sources, used for status, mask and clear vectors.
	typedef struct packed {
		logic       in_low;
		logic       temp;
		logic [2:0] bilim;
		logic [1:0] lilim;
		logic [4:0] uv;
		logic [4:0] ov;
	} pgs_irq_t;
	// Input-low and temperature warning start masked.
	localparam pgs_irq_t MASK_RST = 17'h18000;

	// Factory configuration of the general pins and monitored rails.
	typedef struct packed {
		logic       pg_in_on;
		logic [1:0] pg_in_pin;
		logic [4:0] pg_in_rails;
		logic       start_on;
		logic [1:0] start_pin;
		logic [2:0] dvs_on;
		logic [5:0] dvs_pin;
		logic [1:0] mode_on;
		logic [3:0] mode_pin;
		logic [4:0] rst_rails;
	} pgs_cfg_t;

	// Comparator and converter flags from the analog side.
	typedef struct packed {
		logic       vin_ov;
		logic       vin_uv;
		logic       vin_low;
		logic       temp_warn;
		logic       temp_sd;
		logic [4:0] rail_uv;
		logic [4:0] rail_ov;
		logic [2:0] bck_over;
		logic [2:0] bck_tick;
		logic [1:0] ldo_ilim;
	} pgs_ana_t;

	// External enable trigger sources.
	typedef enum logic [1:0] {
		EXT_TRIG_SEQ  = 2'h0,
		EXT_TRIG_PG   = 2'h1,
		EXT_TRIG_GOOD = 2'h2
	} pgs_trig_t;

	// Sequencer states.
	typedef enum logic [2:0] {
		ST_OFF   = 3'h1,
		ST_RUN   = 3'h2,
		ST_FAULT = 3'h4
	} pgs_state_t;
endpackage : pgs_pkg

// ===== rtl/pgs_supervisor.sv
`timescale 1ns/1ps
module pgs_supervisor #(
	parameter int unsigned TICK_CYCLES = pgs_pkg::TICK_CYC
) (
	input  wire logic            clock,        // 50 MHz clock.
	input  wire logic            rst_n,        // Sync reset, active low.
	input  wire logic [3:0]      general_pin,  // General pin levels.
	input  pgs_pkg::pgs_ana_t    analog_flags, // Analog flags.
	input  pgs_pkg::pgs_cfg_t    factory_config_option, // Factory setup.
	input  wire logic [2:0]      buck_force_pwm, // Force PWM per buck.
	input  wire logic            buck_ss_short,  // Short ramp select.
	input  wire logic [2:0]      buck_light_load, // Light load per buck.
	input  wire logic [2:0][7:0] buck_nominal_setpoint,   // Nominal.
	input  wire logic [2:0][7:0] buck_alternate_setpoint, // Alternate.
	input  wire logic [1:0]      reset_release_delay, // Delay code.
	input  pgs_pkg::pgs_trig_t   enable_out_trigger,  // Enable trigger.
	input  wire logic [3:0]      enable_out_delay_ms, // Enable delay.
	input  wire logic            mask_wr,       // Mask write strobe.
	input  pgs_pkg::pgs_irq_t    mask_wdata,    // Mask write data.
	input  wire logic            status_rd,     // Status read strobe.
	input  wire logic [7:0]      status_rd_addr, // Status address.
	output pgs_pkg::pgs_irq_t    irq_status,    // Sticky status.
	output pgs_pkg::pgs_irq_t    irq_mask,      // Mask register.
	output logic                 input_low_status, // Latched input low.
	output logic [4:0]           rail_enable,   // Buck0-2, LDO0-1.
	output logic [2:0]           buck_soft_start_done, // Ramp done.
	output logic [2:0]           light_load_save_mode, // Save mode.
	output logic [2:0][7:0]      buck_setpoint, // Setpoint in use.
	output logic [1:0]           load_switch_mode, // LDO as switch.
	output logic                 external_enable_output, // Ext enable.
	output logic                 system_reset_output_n, // Reset, low.
	output logic                 interrupt_output_n,    // IRQ, low.
	output logic                 supply_monitor_output  // Supply ok.
);
	import pgs_pkg::*;

	localparam logic [15:0] TICK_LAST = 16'(TICK_CYCLES - 1);
	localparam logic [9:0]  MS_LAST   = 10'(US_PER_MS - 1);
	localparam logic [6:0]  RESTART_T = 7'(RESTART_MS);

	// Synchronised pins and analog flags.
	logic [3:0] pin_s;
	pgs_ana_t   an_s;

	pgs_sync #(.W(4)) u_pin_sync (
		.clock (clock),
		.rst_n (rst_n),
		.d     (general_pin),
		.q     (pin_s)
	);

	pgs_sync #(.W($bits(pgs_ana_t))) u_ana_sync (
		.clock (clock),
		.rst_n (rst_n),
		.d     (analog_flags),
		.q     (an_s)
	);

	// Microsecond and millisecond enables.
	logic [15:0] tick_cnt_q;
	logic [9:0]  us_cnt_q;
	logic        us_tick_q;
	logic        ms_tick_q;

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			tick_cnt_q <= '0;
			us_tick_q  <= 1'b0;
		end else begin
			us_tick_q  <= (tick_cnt_q == TICK_LAST);
			tick_cnt_q <= (tick_cnt_q == TICK_LAST) ? 16'h0000
				: tick_cnt_q + 16'h0001;
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			us_cnt_q  <= '0;
			ms_tick_q <= 1'b0;
		end else begin
			ms_tick_q <= us_tick_q && (us_cnt_q == MS_LAST);
			if (us_tick_q) begin
				us_cnt_q <= (us_cnt_q == MS_LAST) ? 10'h000
					: us_cnt_q + 10'h001;
			end
		end
	end

	// Decoded pin functions.
	pgs_cfg_t cfg;
	assign cfg = factory_config_option;
	wire sysen_w  = !cfg.start_on || pin_s[cfg.start_pin];
	wire pg_in_w  = cfg.pg_in_on && pin_s[cfg.pg_in_pin];
	wire [2:0] scale_n_w = {
		!(cfg.dvs_on[2] && !pin_s[cfg.dvs_pin[5:4]]),
		!(cfg.dvs_on[1] && !pin_s[cfg.dvs_pin[3:2]]),
		!(cfg.dvs_on[0] && !pin_s[cfg.dvs_pin[1:0]])};
	wire [1:0] switch_w = {
		cfg.mode_on[1] && !pin_s[cfg.mode_pin[3:2]],
		cfg.mode_on[0] && !pin_s[cfg.mode_pin[1:0]]};

	// Fault conditions seen by the sequencer and reset logic.
	pgs_irq_t   mask_q;
	pgs_state_t state_q;
	wire [4:0] rail_bad_w   = (an_s.rail_uv | an_s.rail_ov) & rail_enable;
	wire [4:0] rail_trip_w  = (an_s.rail_uv & ~mask_q.uv
		| an_s.rail_ov & ~mask_q.ov) & rail_enable;
	wire in_bad_w = an_s.vin_ov || an_s.vin_uv || an_s.temp_sd;
	wire stay_ok_w  = sysen_w && !in_bad_w;
	wire start_ok_w = stay_ok_w && !an_s.vin_low;
	wire [4:0] rail_want_w = ~cfg.pg_in_rails
		| {5{pg_in_w}};

	// Restart wait timer in milliseconds.
	logic [6:0] wait_cnt_q;
	wire wait_done_w = (wait_cnt_q == RESTART_T);

	always_ff @(posedge clock) begin
		if (!rst_n || state_q != ST_FAULT) begin
			wait_cnt_q <= '0;
		end else if (ms_tick_q && !wait_done_w) begin
			wait_cnt_q <= wait_cnt_q + 7'h01;
		end
	end

	// Power sequencer; a fault wait always falls back through off.
	pgs_state_t state_d;
	always_comb begin
		state_d = state_q;
		case (state_q)
			ST_OFF: begin
				if (start_ok_w) begin
					state_d = ST_RUN;
				end
			end
			ST_RUN: begin
				if (!stay_ok_w) begin
					state_d = ST_OFF;
				end else if (|rail_trip_w) begin
					state_d = ST_FAULT;
				end
			end
			ST_FAULT: begin
				if (wait_done_w) begin
					state_d = ST_OFF;
				end
			end
			default: state_d = ST_OFF;
		endcase
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			state_q     <= ST_OFF;
			rail_enable <= '0;
		end else begin
			state_q     <= state_d;
			rail_enable <= (state_d == ST_RUN) ? rail_want_w : 5'h00;
		end
	end

	// Buck channels.
	logic [2:0] tick_prev_q;
	logic [2:0] bilim_w;
	wire  [2:0] sw_tick_w = an_s.bck_tick & ~tick_prev_q;

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			tick_prev_q <= '0;
		end else begin
			tick_prev_q <= an_s.bck_tick;
		end
	end

	for (genvar i = 0; i < NBUCK; i++) begin : g_buck
		pgs_buck u_buck (
			.clock      (clock),
			.rst_n      (rst_n),
			.us_tick    (us_tick_q),
			.enable     (rail_enable[i]),
			.force_pwm  (buck_force_pwm[i]),
			.ss_short   (buck_ss_short),
			.scale_n    (scale_n_w[i]),
			.light_load (buck_light_load[i]),
			.nominal    (buck_nominal_setpoint[i]),
			.alternate  (buck_alternate_setpoint[i]),
			.sw_tick    (sw_tick_w[i]),
			.sw_over    (an_s.bck_over[i]),
			.ss_done    (buck_soft_start_done[i]),
			.save_mode  (light_load_save_mode[i]),
			.setpoint   (buck_setpoint[i]),
			.ilim_warn  (bilim_w[i])
		);
	end

	// Reset output: held low outside run and by input, unmasked rail or reset-rail faults, released after the delay.
	logic [6:0] rel_cnt_q;
	logic [6:0] dly_w;
	// A tripping rail holds reset already on the edge that enters the wait.
	wire hold_w = in_bad_w || state_q != ST_RUN || |rail_trip_w
		|| |(rail_bad_w & cfg.rst_rails);

	always_comb begin
		case (reset_release_delay)
			2'h0:    dly_w = 7'(RST_DLY0_MS);
			2'h1:    dly_w = 7'(RST_DLY1_MS);
			2'h2:    dly_w = 7'(RST_DLY2_MS);
			default: dly_w = 7'(RST_DLY3_MS);
		endcase
	end

	always_ff @(posedge clock) begin
		if (!rst_n || hold_w) begin
			rel_cnt_q             <= '0;
			system_reset_output_n <= 1'b0;
		end else if (rel_cnt_q == dly_w) begin
			system_reset_output_n <= 1'b1;
		end else if (ms_tick_q) begin
			rel_cnt_q <= rel_cnt_q + 7'h01;
		end
	end

	// External enable: trigger level, then a millisecond delay.
	logic [3:0] ext_cnt_q;
	logic       trig_w;

	always_comb begin
		case (enable_out_trigger)
			EXT_TRIG_SEQ:  trig_w = (state_q == ST_RUN);
			EXT_TRIG_PG:   trig_w = pg_in_w;
			EXT_TRIG_GOOD: trig_w = system_reset_output_n;
			default:       trig_w = 1'b0;
		endcase
	end

	always_ff @(posedge clock) begin
		if (!rst_n || !trig_w) begin
			ext_cnt_q              <= '0;
			external_enable_output <= 1'b0;
		end else if (ext_cnt_q == enable_out_delay_ms) begin
			external_enable_output <= 1'b1;
		end else if (ms_tick_q) begin
			ext_cnt_q <= ext_cnt_q + 4'h1;
		end
	end

	// Interrupt sources and read-to-clear selects.
	pgs_irq_t src_w;
	pgs_irq_t rd_w;
	pgs_irq_t status_d;
	assign src_w.in_low = an_s.vin_low;
	assign src_w.temp   = an_s.temp_warn;
	assign src_w.bilim  = bilim_w;
	assign src_w.lilim  = an_s.ldo_ilim & rail_enable[4:3];
	assign src_w.uv     = an_s.rail_uv & rail_enable;
	assign src_w.ov     = an_s.rail_ov & rail_enable;
	wire rd_in_w = status_rd && status_rd_addr == ST_ADDR_INPUT;
	assign rd_w.in_low = rd_in_w;
	assign rd_w.temp   = status_rd && status_rd_addr == ST_ADDR_TEMP;
	assign rd_w.bilim  = {3{status_rd && status_rd_addr == ST_ADDR_BILIM}};
	assign rd_w.lilim  = {2{status_rd && status_rd_addr == ST_ADDR_LILIM}};
	assign rd_w.uv     = {5{status_rd && status_rd_addr == ST_ADDR_UV}};
	assign rd_w.ov     = {5{status_rd && status_rd_addr == ST_ADDR_OV}};
	// A live source re-sets its bit, so a read never loses it.
	assign status_d = irq_status & ~(rd_w & ~src_w) | src_w;

	// Status, mask and interrupt registers.
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			irq_status         <= '0;
			mask_q             <= MASK_RST;
			interrupt_output_n <= 1'b1;
		end else begin
			irq_status <= status_d;
			if (mask_wr) begin
				mask_q <= mask_wdata;
			end
			interrupt_output_n <= !(|(status_d & ~mask_q));
		end
	end
	assign irq_mask = mask_q;
	assign input_low_status = irq_status.in_low;

	// Live supply monitor and LDO mode; the host keeps the mode pin fixed.
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			supply_monitor_output <= 1'b0;
			load_switch_mode      <= '0;
		end else begin
			supply_monitor_output <= !an_s.vin_low;
			load_switch_mode      <= switch_w;
		end
	end

	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);

	sequence s_fault_enter;
		state_q == ST_RUN ##1 state_q == ST_FAULT;
	endsequence

	chk_reset_thermal: assert property (
		an_s.temp_sd |=> !system_reset_output_n)
		else $error("reset not low on thermal shutdown");
	chk_reset_rail_fault: assert property (
		|(rail_bad_w & cfg.rst_rails) |=> !system_reset_output_n)
		else $error("reset not low on monitored rail fault");
	chk_reset_release: assert property (
		$rose(system_reset_output_n) |-> $past(rel_cnt_q) == $past(dly_w))
		else $error("reset released before its delay");
	chk_irq_set: assert property (
		|(src_w & ~mask_q) |=> !interrupt_output_n)
		else $error("unmasked source did not raise interrupt");
	chk_irq_masked: assert property (
		(status_d & ~mask_q) == '0 |=> interrupt_output_n)
		else $error("interrupt low with only masked status");
	chk_status_hold: assert property (
		status_rd |=> (irq_status & $past(src_w)) == $past(src_w))
		else $error("status cleared while fault present");
	chk_sysen_off: assert property (
		state_q == ST_RUN && !sysen_w |=> state_q == ST_OFF
		&& rail_enable == '0)
		else $error("system enable low did not shut down");
	chk_fault_rails: assert property (
		s_fault_enter |-> rail_enable == '0 && !system_reset_output_n)
		else $error("rails on or reset high in fault wait");
	chk_supply_monitor_output_level: assert property (
		an_s.vin_low ##1 an_s.vin_low |-> !supply_monitor_output)
		else $error("supply monitor high while input low");
endmodule : pgs_supervisor

// ===== rtl/pgs_sync.sv
`timescale 1ns/1ps
module pgs_sync #(
	parameter int unsigned W = 1
) (
	input  wire logic         clock, // System clock.
	input  wire logic         rst_n, // Synchronous reset, active low.
	input  wire logic [W-1:0] d,     // Asynchronous level.
	output logic      [W-1:0] q      // Synchronised level.
);
	logic [W-1:0] meta_q;

	// Two flops; only the second stage leaves this module.
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			meta_q <= '0;
			q      <= '0;
		end else begin
			meta_q <= d;
			q      <= meta_q;
		end
	end
endmodule : pgs_sync

// ===== sim/pgs_host_model.sv
`timescale 1ns/1ps
module pgs_host_model #(
	parameter logic SWITCH_LEVEL = 1'b0
) (
	input  wire logic       clock,       // System clock.
	input  wire logic       en_req,      // Requested enable level.
	input  wire logic       dvs_n,       // Requested scaling level.
	output logic      [3:0] general_pin, // Pin levels to the block.
	output logic      [2:0] sw_tick      // Switching pulses per buck.
);
	logic [2:0] div_q = 3'h0;

	// The mode pin is strapped before power-on and never moved afterwards.
	assign general_pin = {1'b0, SWITCH_LEVEL, dvs_n, en_req};

	// Each buck completes one switching cycle every eight clocks.
	always_ff @(posedge clock) begin
		div_q <= div_q + 3'h1;
	end
	assign sw_tick = {3{div_q[2]}};
endmodule : pgs_host_model

// ===== sim/pgs_supervisor_tb.sv
`timescale 1ns/1ps
module pgs_supervisor_tb;
	import pgs_pkg::*;
	logic            clock = 1'b0;
	logic            rst_n = 1'b0;
	logic            en_req = 1'b0;
	logic            dvs_n = 1'b1;
	logic [3:0]      gp;
	logic [2:0]      tick;
	pgs_ana_t        ana = '0;
	pgs_ana_t        ana_w;
	pgs_cfg_t        cfg = '{1'b0, 2'h0, 5'h00, 1'b1, 2'h0, 3'h1, 6'h01,
		2'h1, 4'h2, 5'h01};
	logic [2:0]      fpwm = 3'h0;
	logic [2:0]      lload = 3'h0;
	logic            ss = 1'b0;
	logic            mwr = 1'b0;
	pgs_irq_t        mdat = '0;
	logic            rd = 1'b0;
	logic [7:0]      ra = 8'h00;
	logic [1:0]      dly = 2'h0;
	pgs_trig_t       trig = EXT_TRIG_SEQ;
	pgs_irq_t        st;
	pgs_irq_t        msk;
	logic            inl;
	logic [4:0]      ren;
	logic [2:0]      ssd;
	logic [2:0]      save;
	logic [2:0][7:0] spt;
	logic [1:0]      ldo_sw;
	logic            eeo;
	logic            rst_o_n;
	logic            irq_n;
	logic            smon;
	int              fails = 0;
	int              num_checks = 0;
	time             t0;

	// Merge the model's switching pulses into the analog flags.
	always @* begin
		ana_w = ana;
		ana_w.bck_tick = tick;
	end

	pgs_host_model pgs_host_model_inst (.clock(clock), .en_req(en_req),
		.dvs_n(dvs_n), .general_pin(gp), .sw_tick(tick));

	// A one-cycle microsecond keeps two reset releases inside the run.
	pgs_supervisor #(.TICK_CYCLES(1)) pgs_supervisor_inst (
		.clock(clock), .rst_n(rst_n), .general_pin(gp),
		.analog_flags(ana_w), .factory_config_option(cfg),
		.buck_force_pwm(fpwm), .buck_ss_short(ss), .buck_light_load(lload),
		.buck_nominal_setpoint({3{8'h3C}}),
		.buck_alternate_setpoint({3{8'hA5}}),
		.reset_release_delay(dly), .enable_out_trigger(trig),
		.enable_out_delay_ms(4'h1), .mask_wr(mwr), .mask_wdata(mdat),
		.status_rd(rd), .status_rd_addr(ra), .irq_status(st),
		.irq_mask(msk), .input_low_status(inl), .rail_enable(ren),
		.buck_soft_start_done(ssd), .light_load_save_mode(save),
		.buck_setpoint(spt), .load_switch_mode(ldo_sw),
		.external_enable_output(eeo), .system_reset_output_n(rst_o_n),
		.interrupt_output_n(irq_n), .supply_monitor_output(smon));

	// Free-running 50 MHz clock.
	initial begin
		forever #10 clock = ~clock;
	end

	task automatic cyc(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask : cyc

	task automatic chk(input logic [31:0] got, input logic [31:0] exp,
		input string m);
		num_checks++;
		if (got !== exp) begin
			fails++;
			$display("BAD %0t %s got %0h exp %0h", $time, m, got, exp);
		end
	endtask : chk

	function automatic int el();
		return int'(($time - t0) / 20);
	endfunction : el

	task automatic give_verdict();
		$display("checks %0d mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : give_verdict

	task automatic lost();
		fails++;
		$display("BAD %0t wait ran out", $time);
		give_verdict();
	endtask : lost

	task automatic rd_st(input logic [7:0] a);
		ra = a;
		rd = 1'b1;
		cyc(1);
		rd = 1'b0;
		cyc(1);
	endtask : rd_st

	task automatic wait_rails();
		int n;
		for (n = 0; n < 20 && ren !== 5'h1F; n++) cyc(1);
		if (n == 20) lost();
		t0 = $time;
	endtask : wait_rails

	// Values held while reset is applied.
	task automatic t_reset();
		chk(irq_n, 1'b1, "irq idle in reset");
		chk(msk, MASK_RST, "mask reset value");
		chk(rst_o_n, 1'b0, "reset out low");
		$display("test reset done");
	endtask : t_reset

	// Enable pin, soft-start, external enable, reset release, shutdown.
	task automatic t_start();
		int n;
		cyc(20);
		chk(ren, 5'h00, "rails off while disabled");
		en_req = 1'b1;
		wait_rails();
		for (n = 0; n < 600 && ssd[0] !== 1'b1; n++) cyc(1);
		if (n == 600) lost();
		chk(el() >= 475 && el() <= 525, 1'b1, "long ramp");
		for (n = 0; n < 1500 && eeo !== 1'b1; n++) cyc(1);
		if (n == 1500) lost();
		chk(el() >= 900 && el() <= 1100, 1'b1, "ext enable");
		trig = EXT_TRIG_GOOD;
		cyc(2);
		chk(eeo, 1'b0, "enable waits for reset");
		for (n = 0; n < 22000 && rst_o_n !== 1'b1; n++) cyc(1);
		if (n == 22000) lost();
		chk(el() >= 19000 && el() <= 21000, 1'b1, "release");
		t0 = $time;
		for (n = 0; n < 1500 && eeo !== 1'b1; n++) cyc(1);
		if (n == 1500) lost();
		chk(el() >= 900 && el() <= 1100, 1'b1, "after reset");
		ana.temp_sd = 1'b1;
		cyc(5);
		chk(rst_o_n, 1'b0, "thermal reset");
		chk({ren, eeo}, 6'h00, "thermal off");
		ss = 1'b1;
		dly = 2'h1;
		ana.temp_sd = 1'b0;
		wait_rails();
		for (n = 0; n < 350 && ssd[0] !== 1'b1; n++) cyc(1);
		if (n == 350) lost();
		chk(el() >= 238 && el() <= 262, 1'b1, "short ramp");
		$display("test start done");
	endtask : t_start

	// Light-load mode, scaling select and LDO mode pin.
	task automatic t_modes();
		lload = 3'h7;
		fpwm = 3'h2;
		cyc(3);
		chk(save, 3'h5, "save mode per buck");
		dvs_n = 1'b0;
		cyc(5);
		chk(spt[0], 8'hA5, "alternate setpoint");
		dvs_n = 1'b1;
		cyc(5);
		chk(spt[0], 8'h3C, "nominal setpoint");
		chk(ldo_sw[0], 1'b1, "pin low gives switch");
		$display("test modes done");
	endtask : t_modes

	// Interrupt sources, masks and read-to-clear.
	task automatic t_irq();
		ana.vin_low = 1'b1;
		cyc(5);
		chk(smon, 1'b0, "monitor low");
		chk(inl, 1'b1, "input low latched");
		chk(irq_n, 1'b1, "input low masked");
		ana.vin_low = 1'b0;
		cyc(5);
		chk(smon, 1'b1, "monitor follows live");
		chk(inl, 1'b1, "still latched");
		rd_st(ST_ADDR_INPUT);
		chk(inl, 1'b0, "cleared by read");
		mdat = '0;
		mwr = 1'b1;
		cyc(1);
		mwr = 1'b0;
		ana.temp_warn = 1'b1;
		cyc(5);
		chk(irq_n, 1'b0, "warning raises irq");
		rd_st(ST_ADDR_TEMP);
		chk({st.temp, irq_n}, 2'b10, "persists");
		ana.temp_warn = 1'b0;
		cyc(4);
		rd_st(8'h20);
		chk(irq_n, 1'b0, "other address ignored");
		rd_st(ST_ADDR_TEMP);
		chk({st.temp, irq_n}, 2'b01, "cleared");
		ana.bck_over[0] = 1'b1;
		cyc(100);
		chk(st.bilim[0], 1'b0, "short run");
		cyc(80);
		chk({st.bilim[0], irq_n}, 2'b10, "sixteen run");
		ana.bck_over[0] = 1'b0;
		mdat.bilim = 3'h1;
		mwr = 1'b1;
		cyc(1);
		mwr = 1'b0;
		cyc(2);
		chk(irq_n, 1'b1, "masked source");
		$display("test irq done");
	endtask : t_irq

	// Longer release code, then a rail fault drops all and restarts.
	task automatic t_fault();
		int n;
		for (n = 0; n < 42000 && rst_o_n !== 1'b1; n++) cyc(1);
		if (n == 42000) lost();
		chk(el() >= 38000 && el() <= 42000, 1'b1, "code 1");
		ana.rail_uv[0] = 1'b1;
		t0 = $time;
		cyc(5);
		chk({rst_o_n, ren}, 6'h00, "rail fault");
		ana.rail_uv[0] = 1'b0;
		for (n = 0; n < 12000 && ren !== 5'h1F; n++) cyc(1);
		if (n == 12000) lost();
		chk(el() >= 9000 && el() <= 11000, 1'b1, "restart");
		en_req = 1'b0;
		cyc(5);
		chk(ren, 5'h00, "enable low shuts down");
		$display("test fault done");
	endtask : t_fault

	// Stop a run that hangs.
	initial begin
		repeat (90000) @(posedge clock);
		lost();
	end

	initial begin
		cyc(3);
		t_reset();
		rst_n = 1'b1;
		t_start();
		t_modes();
		t_irq();
		t_fault();
		give_verdict();
	end
endmodule : pgs_supervisor_tb
